//--- common/acs_pkg.sv
// Purpose: shared constants for the converter channel sequencer control block
// Assumes: one 250 MHz clock, AHB-Lite register access
// Notes:   control word layout keeps the converter's own bit positions
package acs_pkg;
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned CONV_PERIODS   = 13;
  localparam int unsigned RES_BITS       = 12;
  // byte offsets of the bus-visible registers
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_RAW        = 8'h08;
  localparam logic [7:0]  OFS_RESULT     = 8'h0C;
  // control word fields
  localparam int unsigned B_RANGE        = 0;
  localparam int unsigned B_SEQ_LO       = 1;
  localparam int unsigned B_SEQ_HI       = 2;
  localparam int unsigned B_TYPE_LO      = 3;
  localparam int unsigned B_TYPE_HI      = 4;
  localparam int unsigned B_ADDR_LO      = 5;
  localparam int unsigned B_ADDR_HI      = 6;
  localparam int unsigned B_CODING       = 9;
  localparam int unsigned B_PWR_LO       = 10;
  localparam int unsigned B_PWR_HI       = 11;
  localparam int unsigned CTRL_W         = 12;
  localparam logic [11:0] CTRL_RST       = 12'h000;
  localparam logic [11:0] CTRL_WMASK     = 12'hF7F;
  // input type encodings {hi,lo}
  localparam logic [1:0]  TYPE_SINGLE    = 2'h0;
  localparam logic [1:0]  TYPE_PSEUDO    = 2'h1;
  localparam logic [1:0]  TYPE_DIFF      = 2'h2;
  // sequencer encodings {hi,lo}
  localparam logic [1:0]  SEQ_OFF        = 2'h0;
  localparam logic [1:0]  SEQ_RUN        = 2'h3;
  // negative input code meaning analog ground
  localparam logic [2:0]  NEG_GND        = 3'h4;
  localparam logic [11:0] TWOS_FLIP      = 12'h800;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;
  typedef enum logic [1:0] {ACS_IDLE, ACS_CONV, ACS_DONE} acs_state_e;
endpackage

//--- core/acs_core.sv
// Purpose: control of a four-input 12-bit converter: input decode, sequencer, timing, coding
// Assumes: conv_start_n and conv_clock_in are synchronous to hclk; one OKAY AHB-Lite slave
// Notes:   sar_bit_i is the comparator decision taken on each converter clock
// How it works
// - type bits pick single, differential or pseudo
// - single-ended: address picks positive, negative grounded
// - differential pairs 0/1, 1/0, 2/3, 3/2
// - pseudo differential pairs same as differential
// - conversion takes thirteen converter clock periods
// - new start before thirteen periods aborts the conversion
// - sequencer off: last written address converts
// - sequencer on: channel 0 to final, repeat
// - differential sequencing skips inverse pairs
// - sequencer steps on conversion start falling edge
// - inputs sampled then disconnected during conversion
// - coding bit selects binary or twos complement
// - range bit selects reference or double span
// - power bits select power saving behaviour
// - coding bit sits at control bit 9
// - channel address at control bits 6,5
// - input type at control bits 4,3
// - sequencer bits at control bits 2,1
`timescale 1ns/1ps
module acs_core
(
  input  wire logic        hclk,            // system clock
  input  wire logic        hresetn,         // async reset, active low
  input  wire logic        hsel,            // slave select
  input  wire logic [7:0]  haddr,           // byte address
  input  wire logic [1:0]  htrans,          // transfer type
  input  wire logic        hwrite,          // write strobe
  input  wire logic [2:0]  hsize,           // transfer size
  input  wire logic        hready,          // bus ready
  input  wire logic [31:0] hwdata,          // write data
  output logic      [31:0] hrdata,          // read data
  output logic             hreadyout,       // slave ready
  output logic             hresp,           // always OKAY
  input  wire logic        conv_start_n,    // conversion start, active low
  input  wire logic        conv_clock_in,   // converter clock
  input  wire logic        sar_bit_i,       // comparator decision
  output logic      [2:0]  pos_sel,         // positive input pin
  output logic      [2:0]  neg_sel,         // negative input pin, 4 = ground
  output logic             track,           // inputs connected to arrays
  output logic             range_double,    // 0 to 2xref span
  output logic      [1:0]  power_sel,       // power mode bits
  output logic             busy,            // conversion running
  output logic             done_pulse       // result valid, one cycle
);
  typedef struct packed {
    logic [11:0]          ctrl;
    logic [1:0]           chan;
    acs_pkg::acs_state_e  st;
    logic [3:0]           cnt;
    logic [11:0]          sar;
    logic [11:0]          raw;
    logic [11:0]          res;
    logic                 cs_prev;
    logic                 ck_prev;
    logic                 aborted;
    logic                 wr_pend;
    logic                 wr_is;
    logic [7:0]           addr;
    logic [31:0]          rdata;
    logic [2:0]           pos;
    logic [2:0]           neg;
    logic                 track;
    logic                 done;
    logic                 busy;
  } acs_s;

  acs_s q_q;
  acs_s d_d;

  logic [1:0] ityp;
  logic [1:0] seqm;
  logic [1:0] fin;
  logic       cs_fall;
  logic       ck_rise;
  logic       ck_fall;

  // input routing for one channel address under one type
  function automatic logic [5:0] route(input logic [1:0] typ, input logic [1:0] a);
    logic [2:0] p;
    logic [2:0] n;
    p = {1'b0, a};
    n = acs_pkg::NEG_GND;
    // type decode; reserved type pairs as differential
    if (typ != acs_pkg::TYPE_SINGLE)
    begin
      // partner is the other pin of the pair
      n = {1'b0, a[1], ~a[0]};
    end
    // single-ended keeps ground on the negative side
    return {p, n};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign ityp    = q_q.ctrl[acs_pkg::B_TYPE_HI:acs_pkg::B_TYPE_LO];
  assign seqm    = q_q.ctrl[acs_pkg::B_SEQ_HI:acs_pkg::B_SEQ_LO];
  assign fin     = q_q.ctrl[acs_pkg::B_ADDR_HI:acs_pkg::B_ADDR_LO];
  assign cs_fall = q_q.cs_prev & ~conv_start_n;
  assign ck_rise = ~q_q.ck_prev & conv_clock_in;
  assign ck_fall = q_q.ck_prev & ~conv_clock_in;

  always_comb
  begin
    logic [5:0]  rt;
    logic [1:0]  nxt;
    logic        diffm;
    logic [11:0] coded;
    rt    = 6'h00;
    nxt   = 2'h0;
    coded = 12'h000;
    diffm = (ityp != acs_pkg::TYPE_SINGLE);
    d_d   = q_q;
    d_d.cs_prev = conv_start_n;
    d_d.ck_prev = conv_clock_in;
    d_d.done    = 1'b0;

    // bus data phase completes the write
    if (q_q.wr_pend)
    begin
      d_d.wr_pend = 1'b0;
      // fixed field positions; reserved bit 7 stays 0
      if (q_q.wr_is && q_q.addr == acs_pkg::OFS_CTRL)
      begin
        d_d.ctrl = hwdata[acs_pkg::CTRL_W-1:0] & acs_pkg::CTRL_WMASK;
        // new write restarts the channel choice
        d_d.chan = 2'h0;
      end
    end
    if (hsel && hready && htrans == acs_pkg::HTRANS_NONSEQ)
    begin
      d_d.wr_pend = hwrite;
      d_d.wr_is   = hwrite;
      d_d.addr    = haddr;
      if (haddr == acs_pkg::OFS_CTRL)
        d_d.rdata = {20'h00000, q_q.ctrl};
      else if (haddr == acs_pkg::OFS_STATUS)
        d_d.rdata = {25'h0000000, q_q.aborted, q_q.st == acs_pkg::ACS_CONV, q_q.chan,
                     q_q.cnt[1:0], q_q.track};
      else if (haddr == acs_pkg::OFS_RAW)
        d_d.rdata = {20'h00000, q_q.raw};
      else if (haddr == acs_pkg::OFS_RESULT)
        d_d.rdata = {20'h00000, q_q.res};
      else
        d_d.rdata = 32'h00000000;
    end

    case (q_q.st)
      acs_pkg::ACS_IDLE, acs_pkg::ACS_DONE:
      begin
        d_d.st = acs_pkg::ACS_IDLE;
        // start edge launches conversion on current channel
        if (cs_fall)
        begin
          // reserved sequencer codes behave as off
          if (seqm != acs_pkg::SEQ_RUN)
            rt = route(ityp, fin);
          else
            rt = route(ityp, q_q.chan);
          d_d.pos     = rt[5:3];
          d_d.neg     = rt[2:0];
          d_d.track   = 1'b0;
          d_d.st      = acs_pkg::ACS_CONV;
          d_d.busy    = 1'b1;
          d_d.cnt     = 4'h0;
          d_d.sar     = 12'h000;
          d_d.aborted = 1'b0;
          if (seqm == acs_pkg::SEQ_RUN)
          begin
            nxt = diffm ? q_q.chan + 2'h2 : q_q.chan + 2'h1;
            // wrap back to channel 0 after the final
            if (q_q.chan >= (diffm ? {fin[1], 1'b0} : fin))
              nxt = 2'h0;
            d_d.chan = nxt;
          end
        end
      end
      acs_pkg::ACS_CONV:
      begin
        if (ck_rise && q_q.cnt < 4'(acs_pkg::RES_BITS))
          d_d.sar = {q_q.sar[10:0], sar_bit_i};
        // a period counts when its falling edge completes
        if (ck_fall)
          d_d.cnt = q_q.cnt + 4'h1;
        if (ck_fall && q_q.cnt == 4'(acs_pkg::CONV_PERIODS - 1))
        begin
          coded    = q_q.ctrl[acs_pkg::B_CODING] ? q_q.sar ^ acs_pkg::TWOS_FLIP : q_q.sar;
          d_d.raw  = q_q.sar;
          d_d.res  = coded;
          d_d.done = 1'b1;
          d_d.track = 1'b1;
          d_d.st   = acs_pkg::ACS_DONE;
          d_d.busy = 1'b0;
        end
        // new start before all periods aborts
        else if (cs_fall)
        begin
          d_d.aborted = 1'b1;
          d_d.busy    = 1'b0;
          d_d.track   = 1'b1;
          d_d.st      = acs_pkg::ACS_IDLE;
        end
      end
      default:
        d_d.st = acs_pkg::ACS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q_q         <= '0;
      q_q.ctrl    <= acs_pkg::CTRL_RST;
      q_q.st      <= acs_pkg::ACS_IDLE;
      q_q.cs_prev <= 1'b1;
      q_q.track   <= 1'b1;
      q_q.neg     <= acs_pkg::NEG_GND;
    end
    else
      q_q <= d_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign hrdata       = q_q.rdata;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign pos_sel      = q_q.pos;
  assign neg_sel      = q_q.neg;
  assign track        = q_q.track;
  // span select passed to the analog front end
  assign range_double = q_q.ctrl[acs_pkg::B_RANGE];
  // power bits drive the power controller
  assign power_sel    = q_q.ctrl[acs_pkg::B_PWR_HI:acs_pkg::B_PWR_LO];
  assign busy         = q_q.busy;
  assign done_pulse   = q_q.done;

  ////////////////////////////////////////////////////////////////////////////
  // done only after thirteen falling edges
  done_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(done_pulse) |-> $past(q_q.cnt) == 4'(acs_pkg::CONV_PERIODS - 1))
    else $error("result before thirteen periods");
  abort_clean_a: assert property (@(posedge hclk) disable iff (!hresetn)
    busy && cs_fall && !ck_fall |=> !done_pulse && q_q.aborted)
    else $error("abort did not stop conversion");
  track_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    busy |-> !track)
    else $error("inputs connected during conversion");
  single_gnd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(busy) && ityp == acs_pkg::TYPE_SINGLE |-> neg_sel == acs_pkg::NEG_GND)
    else $error("single-ended negative not ground");
  diff_pair_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(busy) && ityp == acs_pkg::TYPE_DIFF |-> neg_sel == (pos_sel ^ 3'h1))
    else $error("differential pairing wrong");
  seq_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(busy) && seqm == acs_pkg::SEQ_OFF |-> pos_sel[1:0] == fin)
    else $error("wrong channel with sequencer off");
  no_inverse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(busy) && seqm == acs_pkg::SEQ_RUN && ityp != acs_pkg::TYPE_SINGLE
    |-> !pos_sel[0])
    else $error("inverse pair converted");
  coding_a: assert property (@(posedge hclk) disable iff (!hresetn)
    done_pulse |-> q_q.res == (q_q.ctrl[acs_pkg::B_CODING] ? q_q.raw ^ acs_pkg::TWOS_FLIP
                               : q_q.raw))
    else $error("result coding wrong");
  // start edge starts conversion next cycle
  start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !busy && cs_fall |=> busy)
    else $error("start edge ignored");
  pseudo_pair_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(busy) && ityp == acs_pkg::TYPE_PSEUDO |-> neg_sel == (pos_sel ^ 3'h1))
    else $error("pseudo differential pairing wrong");
  seq_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(busy) && seqm == acs_pkg::SEQ_RUN |-> pos_sel[1:0] <= fin)
    else $error("sequence beyond final channel");
  seq_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !busy && cs_fall && seqm == acs_pkg::SEQ_RUN && ityp == acs_pkg::TYPE_SINGLE
    && q_q.chan < fin |=> q_q.chan == $past(q_q.chan) + 2'h1)
    else $error("sequencer did not step");
  done_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    done_pulse |-> track && !busy)
    else $error("inputs not reconnected at result");

  conv_done_c: cover property (@(posedge hclk) disable iff (!hresetn) done_pulse);
  abort_c:     cover property (@(posedge hclk) disable iff (!hresetn) $rose(q_q.aborted));
  seq_wrap_c:  cover property (@(posedge hclk) disable iff (!hresetn)
    seqm == acs_pkg::SEQ_RUN && cs_fall && q_q.chan != 2'h0 ##1 q_q.chan == 2'h0);
  pseudo_c:    cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(busy) && ityp == acs_pkg::TYPE_PSEUDO);
endmodule

//--- test/acs_host_model.sv
// Purpose: host-side model pacing conversion start, converter clock and comparator line
// Assumes: each converter clock level lasts three hclk cycles
// Notes:   clock idles low between frames; the comparator line flips once no bit is owed
`timescale 1ns/1ps
module acs_host_model
(
  input  wire logic hclk,          // system clock
  output logic      conv_start_n,  // start request, active low
  output logic      conv_clock_in, // converter clock
  output logic      sar_bit_i      // comparator decision
);
  initial
  begin
    conv_start_n  = 1'b1;
    conv_clock_in = 1'b0;
    sar_bit_i     = 1'b0;
  end
  task automatic start();
    @(posedge hclk);
    conv_start_n <= 1'b0;
    repeat (3) @(posedge hclk);
    conv_start_n <= 1'b1;
  endtask
  task automatic clocks(input logic [11:0] val, input int n);
    for (int i = 0; i < n; i++)
    begin
      sar_bit_i <= (i < 12) ? val[11 - i] : ~sar_bit_i;
      repeat (3) @(posedge hclk);
      conv_clock_in <= 1'b1;
      repeat (3) @(posedge hclk);
      conv_clock_in <= 1'b0;
    end
    sar_bit_i <= ~sar_bit_i;
  endtask
endmodule

//--- test/tb.sv
// Purpose: self-checking bench for the converter control block
// Assumes: zero wait-state bus; the host model paces the converter clock
// Notes:   every completed conversion is split 12 + 1 periods to expose early completion
`timescale 1ns/1ps
module tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans, power_sel;
  logic [2:0]  hsize, pos_sel, neg_sel;
  logic [31:0] hwdata, hrdata, rd;
  logic        conv_start_n, conv_clock_in, sar_bit_i, track, range_double, busy, done_pulse;
  logic [1:0]  ty;
  int          failures, check_count, cycles, dones, d;
  acs_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv_start_n(conv_start_n),
    .conv_clock_in(conv_clock_in), .sar_bit_i(sar_bit_i), .pos_sel(pos_sel),
    .neg_sel(neg_sel), .track(track), .range_double(range_double), .power_sel(power_sel),
    .busy(busy), .done_pulse(done_pulse));
  acs_host_model u_host (.hclk(hclk), .conv_start_n(conv_start_n),
    .conv_clock_in(conv_clock_in), .sar_bit_i(sar_bit_i));
  always #2 hclk = ~hclk;
  // timeout far above the ~2000 cycles the tests need
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (done_pulse === 1'b1)
      dones <= dones + 1;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= acs_pkg::HTRANS_NONSEQ;
    hsize  <= acs_pkg::HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic conv(input logic [11:0] v, input logic [2:0] p, input logic [2:0] n,
                      input logic cod);
    int d0;
    d0 = dones;
    u_host.start();
    @(negedge hclk);
    check("pos_sel", 32'(pos_sel), 32'(p));
    check("neg_sel", 32'(neg_sel), 32'(n));
    check("busy track", 32'({busy, track}), 32'h2);
    u_host.clocks(v, 12);
    repeat (4) @(negedge hclk);
    check("early done", 32'(dones - d0), 32'h0);
    u_host.clocks(v, 1);
    for (int k = 0; k < 20 && dones == d0; k++)
      @(negedge hclk);
    check("done", 32'(dones - d0), 32'h1);
    check("idle", 32'({busy, track}), 32'h1);
    bus(1'b0, acs_pkg::OFS_RAW, 32'h0);
    check("raw", rd, 32'(v));
    bus(1'b0, acs_pkg::OFS_RESULT, 32'h0);
    check("coded", rd, 32'(cod ? v ^ acs_pkg::TWOS_FLIP : v));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hclk    = 1'b0;
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 8'h00;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = acs_pkg::HSIZE_WORD;
    hwdata  = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, acs_pkg::OFS_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    bus(1'b0, acs_pkg::OFS_STATUS, 32'h0);
    check("status reset", rd & 32'h41, 32'h1);
    bus(1'b1, acs_pkg::OFS_CTRL, 32'hFFFFFFFF);
    bus(1'b0, acs_pkg::OFS_CTRL, 32'h0);
    check("ctrl rw", rd, 32'hF7F);
    check("range power", 32'({range_double, power_sel}), 32'h7);
    bus(1'b1, 8'h10, 32'h5);
    bus(1'b0, 8'h10, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b1, acs_pkg::OFS_CTRL, 32'h400);
    @(negedge hclk);
    check("power", 32'({range_double, power_sel}), 32'h1);
    check("hresp", 32'(hresp), 32'h0);
    $display("test registers done");
    for (int t = 0; t < 3; t++)
      for (int a = 0; a < 4; a++)
      begin
        ty = (t == 0) ? acs_pkg::TYPE_SINGLE
           : (t == 1) ? acs_pkg::TYPE_DIFF : acs_pkg::TYPE_PSEUDO;
        // each write picks the next channel
        bus(1'b1, acs_pkg::OFS_CTRL, (32'(a % 2) << 9) | (32'(a) << 5) | (32'(ty) << 3));
        conv(12'(12'h3C5 * (a + 1 + t)), 3'(a),
             (t == 0) ? acs_pkg::NEG_GND : 3'(a ^ 1), 1'(a % 2));
      end
    $display("test input decode done");
    bus(1'b1, acs_pkg::OFS_CTRL, 32'h066);
    for (int i = 0; i < 5; i++)
      conv(12'(12'h801 + i), 3'(i % 4), acs_pkg::NEG_GND, 1'b0);
    bus(1'b1, acs_pkg::OFS_CTRL, 32'h056);
    for (int i = 0; i < 3; i++)
      conv(12'(12'h7F0 + i), 3'((i % 2) * 2), 3'((i % 2) * 2 + 1), 1'b0);
    // reserved sequencer code behaves as off
    bus(1'b1, acs_pkg::OFS_CTRL, 32'h042);
    conv(12'h5A5, 3'h2, acs_pkg::NEG_GND, 1'b0);
    $display("test sequencer done");
    bus(1'b1, acs_pkg::OFS_CTRL, 32'h0);
    d = dones;
    u_host.start();
    u_host.clocks(12'h123, 5);
    u_host.start();
    bus(1'b0, acs_pkg::OFS_STATUS, 32'h0);
    check("aborted", 32'(rd[6]), 32'h1);
    check("no result", 32'(dones - d), 32'h0);
    $display("test abort done");
    conclude();
  end
endmodule
